// File: iswc_pkg.sv
// constants and carrier types for the interrupt, sleep and wake controller
package iswc_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          PC_W            = 13;
  localparam logic [7:0]  CORE_CTRL_OFF   = 8'h00;
  localparam logic [7:0]  PERIPH_FLAG_OFF = 8'h04;
  localparam logic [7:0]  PERIPH_EN_OFF   = 8'h08;
  localparam logic [7:0]  PIN_MASK_OFF    = 8'h0c;
  localparam logic [7:0]  PORT_READ_OFF   = 8'h10;
  localparam logic [7:0]  ANALOG_SEL_OFF  = 8'h14;
  localparam logic [7:0]  WDOG_CTRL_OFF   = 8'h18;
  localparam logic [7:0]  STATUS_OFF      = 8'h1c;
  // core_irq_ctrl_reg fields
  localparam int          CC_EXT_FLAG     = 0;
  localparam int          CC_PORT_FLAG    = 1;
  localparam int          CC_TMR_FLAG     = 2;
  localparam int          CC_EXT_EN       = 3;
  localparam int          CC_PORT_EN      = 4;
  localparam int          CC_TMR_EN       = 5;
  localparam int          CC_EDGE_POL     = 6;
  localparam int          CC_GIE          = 7;
  // periph_irq_flag_reg / periph_irq_enable_reg fields
  localparam int          PF_MATCH        = 0;
  localparam int          PF_EEPROM       = 1;
  localparam int          PF_MEAS         = 2;
  localparam int          PF_W            = 3;
  localparam int          WC_SOFT_EN      = 0;
  localparam int          ST_SLEEP        = 0;
  localparam int          ST_WDOG_LSB     = 16;
  localparam int          EXT_PIN_BIT     = 2;
  localparam int          WDOG_FUSE_BIT   = 3;
  localparam int          WDOG_W          = 16;
  localparam int          PRES_W          = 8;
  localparam logic [7:0]  CORE_CTRL_RST   = 8'h00;
  localparam logic [2:0]  PERIPH_RST      = 3'h0;
  localparam logic [7:0]  PIN_MASK_RST    = 8'h00;
  localparam logic [7:0]  ANALOG_SEL_RST  = 8'h00;
  localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [3:0]  IDX_BAD         = 4'hf;

  typedef enum logic [0:0] {
    CORE_RUN   = 1'b0,
    CORE_SLEEP = 1'b1
  } iswc_power_type;

  typedef struct packed {
    logic sleepOp;
    logic wdogClearOp;
    logic returnFromIrqOp;
  } iswc_core_op_type;

  typedef struct packed {
    logic timerAOverflow;
    logic timerMatch;
    logic eepromWriteDone;
    logic slowMeasDone;
  } iswc_event_type;
endpackage : iswc_pkg

// File: iswc_ctrl.sv
// interrupt gathering, vectoring, sleep entry, wake-up and watchdog
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] entry clears global enable, pushes PC, vectors 0004h
// [RULE_02] return op sets global enable again
// [RULE_03] external pin edge chosen by polarity bit
// [RULE_04] selected edge sets external-pin flag
// [RULE_05] external-pin enable clear blocks its request
// [RULE_06] software clears external flag before re-enabling
// [RULE_07] enabled external edge wakes core from sleep
// [RULE_08] masked port change sets port-change flag
// [RULE_09] software reads port before clearing change flag
// [RULE_10] analog pins read zero, make no events
// [RULE_11] pin events serviced within two instruction cycles
// [RULE_12] only return PC saved; software saves rest
// [RULE_13] core flags in control, peripherals separate
// [RULE_14] six interrupt sources accepted
// [RULE_15] sleep op enters sleep state
// [RULE_16] reset pin, watchdog, enabled interrupts wake
// [RULE_17] watchdog cleared by clear, sleep, wake
// [RULE_18] 16-bit watchdog on slow tick, shared prescaler
// [RULE_19] fuse bit 3 forces watchdog, else soft
// [RULE_20] watchdog overflow wakes sleeper, resets runner
// [RULE_21] software turns comparator off before sleep
// [RULE_22] timer wrap sets overflow flag
// [RULE_23] timer overflow never wakes from sleep
// [RULE_24] port compared to last read, mismatches ORed
// [RULE_25] request needs flag, enable and global enable
module iswc_ctrl
  import iswc_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [iswc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [iswc_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  input  wire logic [7:0]                 portPins,
  input  wire logic                       extResetPin_n,
  input  wire logic [7:0]                 userCfgWordZero,
  input  wire logic                       slowClkTick,
  input  wire logic                       presToWdog,
  input  wire logic [2:0]                 presRatio,
  input  wire iswc_pkg::iswc_core_op_type coreOps,
  input  wire iswc_pkg::iswc_event_type   events,
  input  wire logic [iswc_pkg::PC_W-1:0]  returnPc,
  output logic                            irqRequest,
  output logic                            irqEntry,
  output logic [iswc_pkg::PC_W-1:0]       pcLoad,
  output logic [iswc_pkg::PC_W-1:0]       stackPush,
  output logic                            sleeping,
  output logic                            wakeUp,
  output logic                            wdogResetReq
);
  import iswc_pkg::*;

  function automatic logic [3:0] regIndex(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'h0 || a > STATUS_OFF) begin
      return IDX_BAD;
    end
    return a[5:2];
  endfunction : regIndex

  // ---------------- bus channel state
  logic                awHeld_r, awHeld_nxt;
  logic                wHeld_r, wHeld_nxt;
  logic [ADDR_W-1:0]   awAddr_r, awAddr_nxt;
  logic [31:0]         wData_r, wData_nxt;
  logic                wLane0_r, wLane0_nxt;
  logic                bvalid_r, bvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt;
  logic                rvalid_r, rvalid_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [1:0]          rresp_r, rresp_nxt;
  logic                doWrite;
  logic [3:0]          wIdx;
  logic                arTake;
  logic                portRead;

  // ---------------- controller state
  logic [7:0]          coreCtrl_r, coreCtrl_nxt;
  logic [PF_W-1:0]     pFlag_r, pFlag_nxt;
  logic [PF_W-1:0]     pEn_r, pEn_nxt;
  logic [7:0]          pinMask_r, pinMask_nxt;
  logic [7:0]          analogSel_r, analogSel_nxt;
  logic                softEn_r, softEn_nxt;
  logic [7:0]          portLatch_r, portLatch_nxt;
  logic                extPrev_r, extPrev_nxt;
  logic                phase_r, phase_nxt;
  iswc_power_type      power_r, power_nxt;
  logic [WDOG_W-1:0]   wdogCnt_r, wdogCnt_nxt;
  logic [PRES_W-1:0]   pres_r, pres_nxt;
  logic                entry_r, entry_nxt;
  logic [PC_W-1:0]     pcLoad_r, pcLoad_nxt;
  logic [PC_W-1:0]     stack_r, stack_nxt;
  logic                wake_r, wake_nxt;
  logic                wdogRst_r, wdogRst_nxt;

  logic [7:0]          portEff;
  logic                extPin;
  logic                extEdge;
  logic [7:0]          mismatch;
  logic                pending;
  logic                wakeCause;
  logic                wdogOn;
  logic                wdogStep;
  logic                wdogOvf;
  logic [PRES_W-1:0]   presMask;

  // ---------------- bus slave
  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready  = !wHeld_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign doWrite  = awHeld_r && wHeld_r && !bvalid_r;
  assign wIdx     = regIndex(awAddr_r);
  assign arTake   = s_axi_arvalid && !rvalid_r;
  assign portRead = arTake && regIndex(s_axi_araddr) == PORT_READ_OFF[5:2];

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt  = wData_r;
    wLane0_nxt = wLane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_nxt  = 1'b1;
      wData_nxt  = s_axi_wdata;
      wLane0_nxt = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (wIdx == IDX_BAD) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (arTake) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0;
      case (regIndex(s_axi_araddr))
        CORE_CTRL_OFF[5:2]:   rdata_nxt[7:0] = coreCtrl_r;
        PERIPH_FLAG_OFF[5:2]: rdata_nxt[PF_W-1:0] = pFlag_r;
        PERIPH_EN_OFF[5:2]:   rdata_nxt[PF_W-1:0] = pEn_r;
        PIN_MASK_OFF[5:2]:    rdata_nxt[7:0] = pinMask_r;
        PORT_READ_OFF[5:2]:   rdata_nxt[7:0] = portEff; // see [RULE_10]
        ANALOG_SEL_OFF[5:2]:  rdata_nxt[7:0] = analogSel_r;
        WDOG_CTRL_OFF[5:2]:   rdata_nxt[WC_SOFT_EN] = softEn_r;
        STATUS_OFF[5:2]: begin
          rdata_nxt[ST_SLEEP] = (power_r == CORE_SLEEP);
          rdata_nxt[ST_WDOG_LSB +: WDOG_W] = wdogCnt_r;
        end
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= 32'h0;
      wLane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r  <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r  <= wData_nxt;
      wLane0_r <= wLane0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // ---------------- source detection
  assign portEff  = portPins & ~analogSel_r; // see [RULE_10]
  assign extPin   = portEff[EXT_PIN_BIT];
  assign extEdge  = coreCtrl_r[CC_EDGE_POL] ? (extPin && !extPrev_r)
                                            : (!extPin && extPrev_r); // see [RULE_03]
  assign mismatch = (portEff ^ portLatch_r) & pinMask_r; // see [RULE_24]

  // see [RULE_25] see [RULE_05] see [RULE_13] see [RULE_14]
  assign pending = |({coreCtrl_r[CC_EXT_FLAG], coreCtrl_r[CC_PORT_FLAG],
                      coreCtrl_r[CC_TMR_FLAG]} &
                     {coreCtrl_r[CC_EXT_EN], coreCtrl_r[CC_PORT_EN],
                      coreCtrl_r[CC_TMR_EN]}) || |(pFlag_r & pEn_r);
  assign irqRequest = pending && coreCtrl_r[CC_GIE];

  // timer overflow left out: the timer is stopped in sleep; see [RULE_23]
  assign wakeCause = !extResetPin_n || wdogOvf
    || (coreCtrl_r[CC_EXT_FLAG] && coreCtrl_r[CC_EXT_EN])   // see [RULE_07]
    || (coreCtrl_r[CC_PORT_FLAG] && coreCtrl_r[CC_PORT_EN])
    || |(pFlag_r & pEn_r); // see [RULE_16]

  // ---------------- watchdog
  assign wdogOn   = userCfgWordZero[WDOG_FUSE_BIT] || softEn_r; // see [RULE_19]
  assign presMask = PRES_W'((9'h2 << presRatio) - 9'h1);
  assign wdogStep = wdogOn && slowClkTick
                 && (!presToWdog || (pres_r & presMask) == presMask); // see [RULE_18]
  assign wdogOvf  = wdogStep && (&wdogCnt_r);

  always_comb begin
    coreCtrl_nxt  = coreCtrl_r;
    pFlag_nxt     = pFlag_r;
    pEn_nxt       = pEn_r;
    pinMask_nxt   = pinMask_r;
    analogSel_nxt = analogSel_r;
    softEn_nxt    = softEn_r;
    portLatch_nxt = portRead ? portEff : portLatch_r; // see [RULE_24]
    extPrev_nxt   = extPin;
    phase_nxt     = !phase_r;
    power_nxt     = power_r;
    wdogCnt_nxt   = wdogCnt_r;
    pres_nxt      = pres_r;
    entry_nxt     = 1'b0;
    pcLoad_nxt    = pcLoad_r;
    stack_nxt     = stack_r;
    wake_nxt      = 1'b0;
    wdogRst_nxt   = 1'b0;
    if (doWrite && wLane0_r) begin
      case (wIdx)
        CORE_CTRL_OFF[5:2]:   coreCtrl_nxt  = wData_r[7:0];
        PERIPH_FLAG_OFF[5:2]: pFlag_nxt     = wData_r[PF_W-1:0];
        PERIPH_EN_OFF[5:2]:   pEn_nxt       = wData_r[PF_W-1:0];
        PIN_MASK_OFF[5:2]:    pinMask_nxt   = wData_r[7:0];
        ANALOG_SEL_OFF[5:2]:  analogSel_nxt = wData_r[7:0];
        WDOG_CTRL_OFF[5:2]:   softEn_nxt    = wData_r[WC_SOFT_EN];
        default: ;
      endcase
    end
    // hardware sets win over a software clear in the same cycle
    if (extEdge) coreCtrl_nxt[CC_EXT_FLAG] = 1'b1; // see [RULE_04]
    if (|mismatch) coreCtrl_nxt[CC_PORT_FLAG] = 1'b1; // see [RULE_08]
    if (events.timerAOverflow) coreCtrl_nxt[CC_TMR_FLAG] = 1'b1; // see [RULE_22]
    if (events.timerMatch) pFlag_nxt[PF_MATCH] = 1'b1;
    if (events.eepromWriteDone) pFlag_nxt[PF_EEPROM] = 1'b1;
    if (events.slowMeasDone) pFlag_nxt[PF_MEAS] = 1'b1;
    // entry only on an instruction boundary: two clocks per instruction
    if (irqRequest && power_r == CORE_RUN && phase_r && !entry_r) begin
      entry_nxt  = 1'b1;
      coreCtrl_nxt[CC_GIE] = 1'b0; // see [RULE_01] see [RULE_11]
      pcLoad_nxt = IRQ_VECTOR;
      stack_nxt  = returnPc; // see [RULE_12]
    end
    if (coreOps.returnFromIrqOp) coreCtrl_nxt[CC_GIE] = 1'b1; // see [RULE_02]
    if (presToWdog && slowClkTick) pres_nxt = pres_r + 8'h1;
    if (wdogStep) wdogCnt_nxt = wdogCnt_r + 16'h1;
    case (power_r)
      CORE_RUN: begin
        if (wdogOvf) wdogRst_nxt = 1'b1; // see [RULE_20]
        if (coreOps.sleepOp) power_nxt = CORE_SLEEP; // see [RULE_15]
      end
      CORE_SLEEP: begin
        if (wakeCause) begin
          power_nxt = CORE_RUN;
          wake_nxt  = 1'b1; // see [RULE_20]
        end
      end
      default: power_nxt = CORE_RUN;
    endcase
    if (coreOps.wdogClearOp || (power_r == CORE_RUN && coreOps.sleepOp)
        || wake_nxt || !wdogOn) begin
      wdogCnt_nxt = '0; // see [RULE_17]
      pres_nxt    = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      coreCtrl_r  <= CORE_CTRL_RST;
      pFlag_r     <= PERIPH_RST;
      pEn_r       <= PERIPH_RST;
      pinMask_r   <= PIN_MASK_RST;
      analogSel_r <= ANALOG_SEL_RST;
      softEn_r    <= 1'b0;
      portLatch_r <= 8'h00;
      extPrev_r   <= 1'b0;
      phase_r     <= 1'b0;
      power_r     <= CORE_RUN;
      wdogCnt_r   <= '0;
      pres_r      <= '0;
      entry_r     <= 1'b0;
      pcLoad_r    <= '0;
      stack_r     <= '0;
      wake_r      <= 1'b0;
      wdogRst_r   <= 1'b0;
    end else begin
      coreCtrl_r  <= coreCtrl_nxt;
      pFlag_r     <= pFlag_nxt;
      pEn_r       <= pEn_nxt;
      pinMask_r   <= pinMask_nxt;
      analogSel_r <= analogSel_nxt;
      softEn_r    <= softEn_nxt;
      portLatch_r <= portLatch_nxt;
      extPrev_r   <= extPrev_nxt;
      phase_r     <= phase_nxt;
      power_r     <= power_nxt;
      wdogCnt_r   <= wdogCnt_nxt;
      pres_r      <= pres_nxt;
      entry_r     <= entry_nxt;
      pcLoad_r    <= pcLoad_nxt;
      stack_r     <= stack_nxt;
      wake_r      <= wake_nxt;
      wdogRst_r   <= wdogRst_nxt;
    end
  end

  assign irqEntry     = entry_r;
  assign pcLoad       = pcLoad_r;
  assign stackPush    = stack_r;
  assign sleeping     = (power_r == CORE_SLEEP);
  assign wakeUp       = wake_r;
  assign wdogResetReq = wdogRst_r;

  // ---------------- checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_entry_vector: assert property ( // see [RULE_01]
    irqEntry |-> pcLoad == IRQ_VECTOR && !coreCtrl_r[CC_GIE]
      && stackPush == $past(returnPc))
    else $error("entry without vector or with enable set");

  a_return_gie: assert property ( // see [RULE_02]
    coreOps.returnFromIrqOp |=> coreCtrl_r[CC_GIE])
    else $error("return did not restore global enable");

  a_edge_flag: assert property ( // see [RULE_04]
    extEdge |=> coreCtrl_r[CC_EXT_FLAG])
    else $error("selected edge lost");

  a_ext_gated: assert property ( // see [RULE_05]
    !coreCtrl_r[CC_EXT_EN] && pFlag_r == '0
      && coreCtrl_r[CC_TMR_FLAG:CC_PORT_FLAG] == 2'h0 |-> !irqRequest)
    else $error("disabled external source requested service");

  a_port_change: assert property ( // see [RULE_08]
    |mismatch |=> coreCtrl_r[CC_PORT_FLAG])
    else $error("port mismatch did not set flag");

  a_analog_zero: assert property ( // see [RULE_10]
    portRead |=> (rdata_r[7:0] & $past(analogSel_r)) == 8'h00)
    else $error("analog pin read nonzero");

  a_entry_delay: assert property ( // see [RULE_11]
    irqRequest && !sleeping && !irqEntry && !coreOps.returnFromIrqOp
      |-> ##[1:2] irqEntry)
    else $error("service later than two cycles");

  a_sleep_entry: assert property ( // see [RULE_15]
    coreOps.sleepOp && !sleeping |=> sleeping && wdogCnt_r == '0)
    else $error("sleep op did not sleep and clear watchdog");

  a_wake_clear: assert property ( // see [RULE_17]
    sleeping && wakeCause |=> wakeUp && !sleeping && wdogCnt_r == '0)
    else $error("wake missed or watchdog not cleared");

  a_wdog_reset: assert property ( // see [RULE_20]
    wdogOvf && !sleeping |=> wdogResetReq ##1 !wdogResetReq)
    else $error("watchdog overflow in run gave no reset pulse");

  c_entry: cover property (irqRequest ##[1:2] irqEntry);
  c_wake_pin: cover property (sleeping && extEdge ##[1:3] wakeUp);
  c_wdog_reset: cover property (wdogResetReq);
  c_port_read: cover property (portRead ##1 !(|mismatch));
endmodule : iswc_ctrl

// File: iswc_core_model.sv
// behavioural core and peripheral source model facing the controller
`timescale 1ns/1ps
module iswc_core_model
  import iswc_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire iswc_pkg::iswc_core_op_type opReq,
  input  wire iswc_pkg::iswc_event_type   evReq,
  input  wire logic                       irqEntry,
  input  wire logic [iswc_pkg::PC_W-1:0]  pcLoad,
  input  wire logic [iswc_pkg::PC_W-1:0]  stackPush,
  input  wire logic                       sleeping,
  input  wire logic                       wdogResetReq,
  output iswc_pkg::iswc_core_op_type      coreOps,
  output iswc_pkg::iswc_event_type        events,
  output logic [iswc_pkg::PC_W-1:0]       returnPc
);
  import iswc_pkg::*;
  logic [PC_W-1:0] savedPc[$];

  // ops and events are one-cycle pulses, one edge after the bench asks
  always @(posedge clock) begin
    coreOps <= opReq;
    events <= evReq;
    if (!rst_n || wdogResetReq) begin
      returnPc <= '0;
      savedPc.delete();
    end else if (irqEntry) begin
      savedPc.push_back(stackPush);
      returnPc <= pcLoad;
    end else if (opReq.returnFromIrqOp && savedPc.size() > 0) begin
      returnPc <= savedPc.pop_back();
    end else if (!sleeping) begin
      returnPc <= returnPc + 13'h0001;
    end
  end
endmodule : iswc_core_model

// File: testbench.sv
// self-checking bench for the interrupt, sleep and wake controller
`timescale 1ns/1ps
module testbench;
  import iswc_pkg::*;
  logic             clock, rst_n, awvalid, awready, wvalid, wready;
  logic             bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]       awaddr, araddr, portPins, userCfgWordZero;
  logic [31:0]      wdata, rdata, rd;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp;
  logic [2:0]       presRatio;
  logic             extResetPin_n, slowClkTick, presToWdog, irqRequest;
  logic             irqEntry, sleeping, wakeUp, wdogResetReq;
  logic [12:0]      pcLoad, stackPush, returnPc, lastPc;
  iswc_core_op_type coreOps, opReq;
  iswc_event_type   events, evReq;
  int               fails, checksDone, k;
  logic [31:0]      c;

  iswc_ctrl iswc_ctrl_i (.clock(clock), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .portPins(portPins),
    .extResetPin_n(extResetPin_n), .userCfgWordZero(userCfgWordZero),
    .slowClkTick(slowClkTick), .presToWdog(presToWdog),
    .presRatio(presRatio), .coreOps(coreOps), .events(events),
    .returnPc(returnPc), .irqRequest(irqRequest), .irqEntry(irqEntry),
    .pcLoad(pcLoad), .stackPush(stackPush), .sleeping(sleeping),
    .wakeUp(wakeUp), .wdogResetReq(wdogResetReq));

  iswc_core_model iswc_core_model_i (.clock(clock), .rst_n(rst_n),
    .opReq(opReq), .evReq(evReq), .irqEntry(irqEntry), .pcLoad(pcLoad),
    .stackPush(stackPush), .sleeping(sleeping),
    .wdogResetReq(wdogResetReq), .coreOps(coreOps), .events(events),
    .returnPc(returnPc));

  always @(posedge clock) lastPc <= returnPc;

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic checkOk(input string what, input logic cond);
    checksDone++;
    if (cond !== 1'b1) begin
      fails++;
      $display("[FAIL] %s expected 1 seen %b", what, cond);
    end
  endtask : checkOk

  task automatic testDone;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : testDone

  task automatic bound(input int n);
    if (n >= 40) begin
      checkOk("bus handshake", 1'b0);
      testDone();
    end
  endtask : bound

  task automatic busWrite(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
    int n = 0;
    logic aw = 1'b1;
    logic w = 1'b1;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((aw || w) && n < 40) begin
      @(posedge clock);
      n++;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    bound(n);
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : busWrite

  task automatic busRead(input logic [7:0] a, input logic [1:0] er,
                         output logic [31:0] d);
    int n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (arready !== 1'b1 && n < 40);
    arvalid <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    bound(n);
    d = rdata;
    check("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : busRead

  task automatic expectReg(input string nm, input logic [7:0] a,
                           input logic [31:0] e);
    logic [31:0] d;
    busRead(a, RESP_OKAY, d);
    check(nm, e, d);
  endtask : expectReg

  task automatic pulse(input iswc_core_op_type o, input iswc_event_type ev);
    @(posedge clock);
    opReq <= o;
    evReq <= ev;
    @(posedge clock);
    opReq <= '0;
    evReq <= '0;
    repeat (2) @(posedge clock);
  endtask : pulse

  task automatic setPins(input logic [7:0] v);
    @(posedge clock);
    portPins <= v;
  endtask : setPins

  task automatic tick(input int n);
    @(posedge clock);
    slowClkTick <= 1'b1;
    repeat (n) @(posedge clock);
    slowClkTick <= 1'b0;
  endtask : tick

  // sel 0 entry, 1 wake, 2 watchdog reset; k counts edges seen
  task automatic waitFor(input int sel, input int lim);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (!(sel == 0 ? irqEntry : sel == 1 ? wakeUp : wdogResetReq)
               && k < lim);
  endtask : waitFor

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {slowClkTick, presToWdog, presRatio, awaddr, araddr, wdata} = '0;
    {portPins, userCfgWordZero, opReq, evReq, fails, checksDone} = '0;
    wstrb = 4'hf;
    extResetPin_n = 1'b1;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    expectReg("ctrl", CORE_CTRL_OFF, 32'h0);
    expectReg("periph en", PERIPH_EN_OFF, 32'h0);
    busRead(8'h20, RESP_SLVERR, rd);
    busWrite(8'h20, 32'hff, RESP_SLVERR);
    for (int p = 0; p < 2; p++) begin
      c = p ? 32'hc8 : 32'h88;
      setPins(p ? 8'h04 : 8'h00);
      busWrite(CORE_CTRL_OFF, c, RESP_OKAY);
      setPins(p ? 8'h00 : 8'h04);
      expectReg("wrong edge", CORE_CTRL_OFF, c);
      setPins(p ? 8'h04 : 8'h00);
      waitFor(0, 8);
      checkOk("latency", k >= 3 && k <= 4);
      check("pcLoad", {19'h0, IRQ_VECTOR}, {19'h0, pcLoad});
      check("stack", {19'h0, lastPc}, {19'h0, stackPush});
      expectReg("entry", CORE_CTRL_OFF, (c & 32'h7f) | 32'h1);
      busWrite(CORE_CTRL_OFF, c & 32'h7f, RESP_OKAY);
      pulse(3'b001, '0);
      expectReg("return", CORE_CTRL_OFF, c);
    end
    busWrite(CORE_CTRL_OFF, 32'hc0, RESP_OKAY);
    setPins(8'h00);
    setPins(8'h04);
    waitFor(0, 8);
    checkOk("masked", k == 8);
    checkOk("no request", !irqRequest);
    expectReg("masked flag", CORE_CTRL_OFF, 32'hc1);
    busWrite(CORE_CTRL_OFF, 32'ha0, RESP_OKAY);
    pulse('0, 4'b1000);
    waitFor(0, 8);
    checkOk("timer entry", k < 8);
    expectReg("timer flag", CORE_CTRL_OFF, 32'h24);
    busWrite(PERIPH_EN_OFF, 32'h7, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      busWrite(CORE_CTRL_OFF, 32'h80, RESP_OKAY);
      pulse('0, 4'b0100 >> i);
      waitFor(0, 8);
      checkOk("periph entry", k < 8);
      expectReg("periph flag", PERIPH_FLAG_OFF, 32'h1 << i);
      busWrite(PERIPH_FLAG_OFF, 32'h0, RESP_OKAY);
    end
    busWrite(ANALOG_SEL_OFF, 32'h1, RESP_OKAY);
    busWrite(PIN_MASK_OFF, 32'h3, RESP_OKAY);
    busWrite(CORE_CTRL_OFF, 32'h10, RESP_OKAY);
    expectReg("port", PORT_READ_OFF, 32'h04);
    setPins(8'h0d);
    expectReg("no change", CORE_CTRL_OFF, 32'h10);
    expectReg("analog 0", PORT_READ_OFF, 32'h0c);
    setPins(8'h0f);
    expectReg("change", CORE_CTRL_OFF, 32'h12);
    busWrite(CORE_CTRL_OFF, 32'h10, RESP_OKAY);
    expectReg("still", CORE_CTRL_OFF, 32'h12);
    expectReg("port 2", PORT_READ_OFF, 32'h0e);
    busWrite(CORE_CTRL_OFF, 32'h10, RESP_OKAY);
    expectReg("cleared", CORE_CTRL_OFF, 32'h10);
    for (int w = 0; w < 4; w++) begin
      busWrite(CORE_CTRL_OFF, 32'h38, RESP_OKAY);
      pulse(3'b100, '0);
      checkOk("asleep", sleeping);
      pulse('0, 4'b1000);
      checkOk("timer no wake", sleeping);
      case (w)
        0: setPins(8'h0b);
        1: setPins(8'h09);
        2: pulse('0, 4'b0010);
        default: begin
          @(posedge clock);
          extResetPin_n <= 1'b0;
        end
      endcase
      waitFor(1, 8);
      extResetPin_n <= 1'b1;
      checkOk("wake", k < 8);
      checkOk("awake", !sleeping);
      busRead(PORT_READ_OFF, RESP_OKAY, rd);
      busWrite(PERIPH_FLAG_OFF, 32'h0, RESP_OKAY);
    end
    presToWdog <= 1'b1;
    busWrite(WDOG_CTRL_OFF, 32'h1, RESP_OKAY);
    tick(10);
    expectReg("wdog count", STATUS_OFF, 32'h50000);
    pulse(3'b010, '0);
    expectReg("wdog clr", STATUS_OFF, 32'h0);
    tick(6);
    pulse(3'b100, '0);
    expectReg("sleep clr", STATUS_OFF, 32'h1);
    @(posedge clock);
    extResetPin_n <= 1'b0;
    waitFor(1, 8);
    extResetPin_n <= 1'b1;
    busWrite(WDOG_CTRL_OFF, 32'h0, RESP_OKAY);
    tick(5);
    expectReg("wdog off", STATUS_OFF, 32'h0);
    userCfgWordZero <= 8'h08;
    presToWdog <= 1'b0;
    slowClkTick <= 1'b1;
    waitFor(2, 66000);
    checkOk("wdog time", k >= 65530 && k <= 65540);
    slowClkTick <= 1'b0;
    testDone();
  end
endmodule : testbench
